// ### core/buffer_ready_monitor.sv
// Buffer-ready pin monitor: registers, socket size select, four pins.
// Assumes socket sizes and register port are synchronous to clock.
//
// Implementation choice: the strobed register port.
`include "ready_pin_consts.svh"
`timescale 1ns/100ps
module buffer_ready_monitor (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [9:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic [135:0] tx_free_size,
   input wire logic [135:0] rx_received_size,
   output logic [3:0] buffer_ready_pin,
   output logic irq
);

   // ****************************************
   // Register state
   // ****************************************
   ready_pin_pkg::cfg_t cfg [`READY_PINS];
   ready_pin_pkg::cfg_t next_cfg [`READY_PINS];
   ready_pin_pkg::reg16_t depth [`READY_PINS];
   ready_pin_pkg::reg16_t next_depth [`READY_PINS];
   logic [15:0] next_rdata;
   logic [3:0] cfg_hit;
   logic [3:0] depth_hit;
   logic status_hit;
   logic mask_hit;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic [3:0] pin_events;

   // ****************************************
   // Socket sizes
   // ****************************************
   ready_pin_pkg::size_t tx_size [`READY_SOCKETS];
   ready_pin_pkg::size_t rx_size [`READY_SOCKETS];
   ready_pin_pkg::size_t watched [`READY_PINS];

   genvar s;
   generate
      for (s = 0; s < `READY_SOCKETS; s++) begin : g_socket
         assign tx_size[s] = tx_free_size[s*`READY_SIZE_W +: `READY_SIZE_W];
         assign rx_size[s] =
            rx_received_size[s*`READY_SIZE_W +: `READY_SIZE_W];
      end
   endgenerate

   // ****************************************
   // Per-pin decode, select and channel
   // ****************************************
   genvar p;
   generate
      for (p = 0; p < `READY_PINS; p++) begin : g_pin
         localparam logic [9:0] CFG_ADDR =
            10'(`READY_BASE + 10'(p) * `READY_STRIDE);
         localparam logic [9:0] DEPTH_ADDR =
            10'(CFG_ADDR + `READY_DEPTH_OFF);
         logic [2:0] socket;
         logic tx_select;

         assign cfg_hit[p] = (addr == CFG_ADDR);
         assign depth_hit[p] = (addr == DEPTH_ADDR);
         assign socket = cfg[p][`CFG_SOCKET_MSB:`CFG_SOCKET_LSB];
         assign tx_select = cfg[p][`CFG_TX_SELECT_BIT];
         assign watched[p] =
            tx_select ? tx_size[socket] : rx_size[socket];

         ready_pin_channel u_channel (
            .clock(clock),
            .rst_n(rst_n),
            .enable(cfg[p][`CFG_ENABLE_BIT]),
            .polarity(cfg[p][`CFG_POLARITY_BIT]),
            .watched_size(watched[p]),
            .depth(depth[p]),
            .pin_level(buffer_ready_pin[p]),
            .assert_pulse(pin_events[p])
         );
      end
   endgenerate

   assign status_hit = (addr == `READY_IRQ_STATUS);
   assign mask_hit = (addr == `READY_IRQ_MASK);

   // ****************************************
   // Register writes
   // ****************************************
   always_comb begin
      for (int i = 0; i < `READY_PINS; i++) begin
         next_cfg[i] = cfg[i];
         next_depth[i] = depth[i];
         if (wr && cfg_hit[i]) begin
            next_cfg[i] = wdata[7:0] & `CFG_WRITE_MASK;
         end
         if (wr && depth_hit[i]) begin
            next_depth[i] = wdata;
         end
      end
   end

   always_ff @(posedge clock) begin
      for (int i = 0; i < `READY_PINS; i++) begin
         if (!rst_n) begin
            cfg[i] <= `CFG_RESET;
         end else begin
            cfg[i] <= next_cfg[i];
         end
      end
   end

   // Depth thresholds have no reset value
   always_ff @(posedge clock) begin
      for (int i = 0; i < `READY_PINS; i++) begin
         depth[i] <= next_depth[i];
      end
   end

   // ****************************************
   // Register reads
   // ****************************************
   always_comb begin
      next_rdata = 16'h0000;
      if (rd) begin
         for (int i = 0; i < `READY_PINS; i++) begin
            if (cfg_hit[i]) begin
               next_rdata = {8'h00, cfg[i]};
            end
            if (depth_hit[i]) begin
               next_rdata = depth[i];
            end
         end
         if (status_hit) begin
            next_rdata = {12'h000, irq_status};
         end
         if (mask_hit) begin
            next_rdata = {12'h000, irq_mask};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ****************************************
   // Interrupt
   // ****************************************
   ready_irq_status u_irq (
      .clock(clock),
      .rst_n(rst_n),
      .events(pin_events),
      .clear_we(wr && status_hit),
      .mask_we(wr && mask_hit),
      .wdata(wdata[3:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

endmodule // buffer_ready_monitor

// ### core/ready_pin_consts.svh
// Constants of the buffer-ready pin monitor: offsets, fields, resets, timing.
// Assumes a 16-bit register port with byte addresses and a 25 MHz core clock.
//
// Summary of operation
// - Watching transmit memory, pin signals while free size >= threshold.
// - Watching receive memory, pin signals while received size >= threshold.
// - Pin goes active one core clock after the rise is detected.
// - Pin goes inactive one core clock after the drop is detected.
// - Pin stays active while the condition holds, and at least 80 ns.
// - Four pins, each with its own read/write config and depth register.
// - Depth registers are undefined after reset; software loads them first.
// - Config low byte resets to zero, so every pin starts disabled.
// - Config bit 7 enables the pin.
// - Config bit 5 picks the active level: zero low, one high.
`ifndef READY_PIN_CONSTS_SVH
`define READY_PIN_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define READY_ADDR_W 10
`define READY_BASE 10'h060
`define READY_STRIDE 10'h004
`define READY_DEPTH_OFF 10'h002
`define READY_CFG0 10'h060
`define READY_DEPTH0 10'h062
`define READY_CFG1 10'h064
`define READY_DEPTH1 10'h066
`define READY_CFG2 10'h068
`define READY_DEPTH2 10'h06A
`define READY_CFG3 10'h06C
`define READY_DEPTH3 10'h06E
`define READY_IRQ_STATUS 10'h070
`define READY_IRQ_MASK 10'h072

// ****************************************
// Fields and resets
// ****************************************
`define READY_PINS 4
`define READY_SOCKETS 8
`define READY_SIZE_W 17
`define CFG_ENABLE_BIT 7
`define CFG_TX_SELECT_BIT 6
`define CFG_POLARITY_BIT 5
`define CFG_SOCKET_MSB 2
`define CFG_SOCKET_LSB 0
`define CFG_WRITE_MASK 8'hE7
`define CFG_RESET 8'h00
`define IRQ_MASK_RESET 4'h0
`define PIN_RESET_LEVEL 1'b1

// ****************************************
// Timing
// ****************************************
`define CLOCK_PERIOD_NS 40
`define MIN_ACTIVE_NS 80
`define MIN_ACTIVE_CYCLES \
   ((`MIN_ACTIVE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ### core/ready_pin_pkg.sv
// Types shared by the buffer-ready pin monitor.
// Assumes the constants header is compiled alongside.
package ready_pin_pkg;

   typedef logic [15:0] reg16_t;
   typedef logic [16:0] size_t;
   typedef logic [7:0] cfg_t;

   typedef enum logic [1:0] {
      pin_idle = 2'b00,
      pin_min_hold = 2'b01,
      pin_on = 2'b10
   } pin_state_t;

endpackage

// ### core/ready_pin_channel.sv
// One buffer-ready pin: compare, minimum hold and polarity.
// Assumes the watched size is already selected and synchronous to clock.
`include "ready_pin_consts.svh"
`timescale 1ns/100ps
module ready_pin_channel (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic polarity,
   input wire ready_pin_pkg::size_t watched_size,
   input wire ready_pin_pkg::reg16_t depth,
   output logic pin_level,
   output logic assert_pulse
);

   localparam logic [1:0] HOLD_LOAD = 2'(`MIN_ACTIVE_CYCLES - 1);

   logic detect, next_detect;
   ready_pin_pkg::pin_state_t state, next_state;
   logic [1:0] hold, next_hold;
   logic next_pin_level, next_assert_pulse;
   logic active;

   // ****************************************
   // Detection and hold
   // ****************************************
   always_comb begin
      next_detect = enable && (watched_size >= {1'b0, depth});
      next_state = state;
      next_hold = hold;
      next_assert_pulse = 1'b0;
      unique case (state)
         ready_pin_pkg::pin_idle: begin
            if (detect) begin
               next_state = ready_pin_pkg::pin_min_hold;
               next_hold = HOLD_LOAD;
               next_assert_pulse = 1'b1;
            end
         end
         ready_pin_pkg::pin_min_hold: begin
            if (hold != 2'h0) begin
               next_hold = hold - 2'h1;
            end else if (detect) begin
               next_state = ready_pin_pkg::pin_on;
            end else begin
               next_state = ready_pin_pkg::pin_idle;
            end
         end
         ready_pin_pkg::pin_on: begin
            if (!detect) begin
               next_state = ready_pin_pkg::pin_idle;
            end
         end
         default: begin
            next_state = ready_pin_pkg::pin_idle;
         end
      endcase
      active = (next_state != ready_pin_pkg::pin_idle);
      next_pin_level = active ? polarity : !polarity;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         detect <= 1'b0;
         state <= ready_pin_pkg::pin_idle;
         hold <= 2'h0;
         pin_level <= `PIN_RESET_LEVEL;
         assert_pulse <= 1'b0;
      end else begin
         detect <= next_detect;
         state <= next_state;
         hold <= next_hold;
         pin_level <= next_pin_level;
         assert_pulse <= next_assert_pulse;
      end
   end

endmodule // ready_pin_channel

// ### core/ready_irq_status.sv
// Sticky event status, mask and level interrupt.
// Assumes write strobes are one cycle long.
`include "ready_pin_consts.svh"
`timescale 1ns/100ps
module ready_irq_status (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] events,
   input wire logic clear_we,
   input wire logic mask_we,
   input wire logic [3:0] wdata,
   output logic [3:0] status,
   output logic [3:0] mask,
   output logic irq
);

   logic [3:0] next_status, next_mask;
   logic next_irq;

   // ****************************************
   // Status update, set wins over clear
   // ****************************************
   always_comb begin
      next_status = status;
      if (clear_we) begin
         next_status = status & ~wdata;
      end
      next_status = next_status | events;
      next_mask = mask_we ? wdata : mask;
      next_irq = |(next_status & next_mask);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         status <= 4'h0;
         mask <= `IRQ_MASK_RESET;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         mask <= next_mask;
         irq <= next_irq;
      end
   end

endmodule // ready_irq_status

// ### test/ready_socket_model.sv
// Far-side model: per-socket free and received sizes.
// Assumes the bench loads sizes and drains received sizes as host reads.
`timescale 1ns/100ps
module ready_socket_model (
   input wire logic clock,
   input wire logic load,
   input wire logic to_tx,
   input wire logic drain,
   input wire logic [2:0] sock,
   input wire logic [16:0] value,
   output logic [135:0] tx_free_size,
   output logic [135:0] rx_received_size
);
   // ****
   // Socket sizes
   // ****
   initial begin
      tx_free_size = '0;
      rx_received_size = '0;
   end
   always @(posedge clock) begin
      if (load && to_tx) tx_free_size[17 * sock +: 17] <= value;
      if (load && !to_tx) rx_received_size[17 * sock +: 17] <= value;
      if (drain) begin
         rx_received_size[17 * sock +: 17] <=
            rx_received_size[17 * sock +: 17] - value;
      end
   end
endmodule // ready_socket_model

// ### test/buffer_ready_monitor_chk.sv
// Port checker of the buffer-ready monitor.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module buffer_ready_monitor_chk (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [9:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic [135:0] tx_free_size,
   input wire logic [135:0] rx_received_size,
   input wire logic [3:0] buffer_ready_pin,
   input wire logic irq
);
   // ****
   // Shadow settings and compare
   // ****
   logic [3:0][7:0] cfg;
   logic [3:0][15:0] dep;
   logic [3:0] det;
   logic [3:0] act;
   assign act = buffer_ready_pin ~^
      {cfg[3][5], cfg[2][5], cfg[1][5], cfg[0][5]};
   always_ff @(posedge clock) begin
      for (int i = 0; i < 4; i++) begin
         if (!rst_n) cfg[i] <= 8'h00;
         else if (wr && addr == 10'h060 + 10'(4 * i))
            cfg[i] <= wdata[7:0] & 8'hE7;
         if (wr && addr == 10'h062 + 10'(4 * i)) dep[i] <= wdata;
         det[i] <= rst_n && cfg[i][7] && {1'b0, dep[i]} <= (cfg[i][6] ?
            tx_free_size[17 * cfg[i][2:0] +: 17] :
            rx_received_size[17 * cfg[i][2:0] +: 17]);
      end
   end
   // ****
   // Assertions
   // ****
   a_rdata_quiet: assert property (@(posedge clock)
      disable iff (!rst_n) !$past(rd) |-> rdata == 16'h0000)
      else $error("rdata not zero without read");
   a_reset_idle: assert property (@(posedge clock)
      !rst_n |=> buffer_ready_pin == 4'hF && irq == 1'b0)
      else $error("outputs not idle after reset");
   a_cfg_read: assert property (@(posedge clock)
      disable iff (!rst_n) rd && addr == 10'h064 |=>
      rdata == {8'h00, cfg[1]}) else $error("config read wrong");
   a_unmapped_read: assert property (@(posedge clock)
      disable iff (!rst_n) rd && addr == 10'h080 |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_mask_off: assert property (@(posedge clock)
      disable iff (!rst_n) wr && addr == 10'h072 && wdata[3:0] == 4'h0
      |=> irq == 1'b0) else $error("irq with mask clear");
   for (genvar g = 0; g < 4; g++) begin : pin_chk
      a_ready_follow: assert property (@(posedge clock)
         disable iff (!rst_n) det[g] && !wr && !$past(wr) |=> act[g])
         else $error("pin not active after detect");
      a_ready_drop: assert property (@(posedge clock)
         disable iff (!rst_n) !det[g] && !$past(det[g]) && !wr &&
         !$past(wr) |=> !act[g]) else $error("pin not released");
      a_min_hold: assert property (@(posedge clock)
         disable iff (!rst_n) $rose(act[g]) && !wr && !$past(wr)
         |=> act[g]) else $error("pin active too short");
   end
endmodule // buffer_ready_monitor_chk

// ### test/buffer_ready_monitor_tb.sv
// Testbench of the buffer-ready monitor with a socket size model.
// Assumes a 25 MHz clock and the register map of the constants header.
`timescale 1ns/100ps
module buffer_ready_monitor_tb;
   // ****
   // Stimulus and checks
   // ****
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic load = 1'b0;
   logic to_tx = 1'b0;
   logic drain = 1'b0;
   logic [2:0] sock = 3'h0;
   logic [16:0] value = 17'h00000;
   logic [15:0] rdata;
   logic [135:0] tx_free_size;
   logic [135:0] rx_received_size;
   logic [3:0] buffer_ready_pin;
   logic irq;
   int failures = 0;
   int samples_checked = 0;
   initial begin
      forever #20 clock = ~clock;
   end
   buffer_ready_monitor DUT (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .tx_free_size(tx_free_size), .rx_received_size(rx_received_size),
      .buffer_ready_pin(buffer_ready_pin), .irq(irq));
   ready_socket_model far_side (.clock(clock), .load(load), .to_tx(to_tx),
      .drain(drain), .sock(sock), .value(value),
      .tx_free_size(tx_free_size), .rx_received_size(rx_received_size));
   task automatic check(input logic [15:0] got, input logic [15:0] want);
      samples_checked++;
      if (got !== want) begin
         failures++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic check_irq(input logic want);
      check({15'h0000, irq}, {15'h0000, want});
   endtask
   task automatic write(input logic [9:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic read(input logic [9:0] a, input logic [15:0] want);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 check(rdata, want);
   endtask
   task automatic size(input logic tx, input logic [2:0] s,
      input logic [16:0] v, input logic dr);
      @(posedge clock);
      to_tx <= tx;
      sock <= s;
      value <= v;
      load <= !dr;
      drain <= dr;
      @(posedge clock);
      load <= 1'b0;
      drain <= 1'b0;
   endtask
   task automatic pins(input int n, input logic [3:0] want);
      repeat (n) @(posedge clock);
      #1 check({12'h000, buffer_ready_pin}, {12'h000, want});
   endtask
   task automatic t_regs;
      pins(0, 4'hF);
      for (int i = 0; i < 4; i++) read(10'h060 + 10'(4 * i), 16'h0000);
      read(10'h080, 16'h0000);
      for (int i = 0; i < 4; i++) write(10'h062 + 10'(4 * i), 16'h1000);
      write(10'h064, 16'hFFFF);
      read(10'h064, 16'h00E7);
      write(10'h064, 16'h0000);
      write(10'h066, 16'hA5C3);
      read(10'h066, 16'hA5C3);
      read(10'h062, 16'h1000);
   endtask
   task automatic t_tx;
      write(10'h072, 16'h0008);
      write(10'h06E, 16'h0800);
      write(10'h06C, 16'h00E5);
      size(1'b1, 3'h5, 17'h007FF, 1'b0);
      pins(4, 4'h7);
      size(1'b1, 3'h5, 17'h00800, 1'b0);
      pins(1, 4'h7);
      pins(1, 4'hF);
      @(posedge clock);
      #1 check_irq(1'b1);
      read(10'h070, 16'h0008);
      read(10'h072, 16'h0008);
      write(10'h070, 16'h0008);
      #1 check_irq(1'b0);
      read(10'h070, 16'h0000);
      write(10'h072, 16'h0000);
   endtask
   task automatic t_rx;
      write(10'h060, 16'h0082);
      size(1'b0, 3'h2, 17'h01000, 1'b0);
      pins(2, 4'hE);
      size(1'b0, 3'h2, 17'h00001, 1'b1);
      pins(1, 4'hE);
      pins(1, 4'hF);
      @(posedge clock);
      value <= 17'h01000;
      load <= 1'b1;
      @(posedge clock);
      load <= 1'b0;
      value <= 17'h00001;
      drain <= 1'b1;
      @(posedge clock);
      drain <= 1'b0;
      pins(1, 4'hE);
      pins(1, 4'hE);
      pins(1, 4'hF);
   endtask
   task automatic t_enable;
      size(1'b0, 3'h2, 17'h01000, 1'b0);
      pins(3, 4'hE);
      write(10'h060, 16'h0002);
      pins(4, 4'hF);
      write(10'h060, 16'h00A2);
      pins(4, 4'hF);
      write(10'h060, 16'h0022);
      pins(4, 4'hE);
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #100000 failures++;
      complete_run();
   end
   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      t_regs();
      t_tx();
      t_rx();
      t_enable();
      complete_run();
   end
endmodule // buffer_ready_monitor_tb
bind buffer_ready_monitor buffer_ready_monitor_chk chk (.clock(clock),
   .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .tx_free_size(tx_free_size),
   .rx_received_size(rx_received_size),
   .buffer_ready_pin(buffer_ready_pin), .irq(irq));
